// >>> design/opv_pkg.sv
// package of constants, types and register map for the otp program/verify controller
package opv_pkg;

  // ---------------------------------------------------------------
  // clock and pin timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;      // 10 MHz system clock
  localparam int T_SETUP_NS    = 2000;     // address/data/voltage set-up, least
  localparam int T_PULSE_NS    = 100000;   // program pulse width, typical
  localparam int T_HOLD_NS     = 20;       // address and data hold, least
  localparam int T_OE_NS       = 300;      // output enable pulse width, least
  localparam int T_ACC_NS      = 183;      // output enable access, longest
  localparam int SYNC_STAGES   = 2;        // flip-flops on the returning data

  localparam int CNT_W = 11;               // width of the phase counter
  localparam logic [CNT_W-1:0] SETUP_CYC =
    CNT_W'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PULSE_CYC =
    CNT_W'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC =
    CNT_W'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OE_CYC  = (T_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // read strobe covers access time, the synchroniser and two spare cycles
  localparam logic [CNT_W-1:0] READ_CYC =
    CNT_W'((ACC_CYC + SYNC_STAGES + 2) > OE_CYC ? (ACC_CYC + SYNC_STAGES + 2) : OE_CYC);

  // ---------------------------------------------------------------
  // array address bounds
  // ---------------------------------------------------------------
  localparam logic [15:0] CHAR_LO = 16'hC000;  // first character array address
  localparam logic [15:0] CHAR_HI = 16'hDFFF;  // last character array address

  // ---------------------------------------------------------------
  // register map (byte offsets) and fields
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_CTRL   = 5'h00;   // op code and go
  localparam logic [4:0] REG_ADDR   = 5'h04;   // array address
  localparam logic [4:0] REG_WDATA  = 5'h08;   // byte to program
  localparam logic [4:0] REG_ROW    = 5'h0C;   // 12-bit character row
  localparam logic [4:0] REG_RDATA  = 5'h10;   // byte read back
  localparam logic [4:0] REG_STATUS = 5'h14;   // busy, done, refused, range
  localparam logic [4:0] REG_ENABLE = 5'h18;   // port enable
  localparam int CTRL_GO_BIT   = 4;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_DONE_BIT   = 1;
  localparam int ST_REFUSE_BIT = 2;
  localparam int ST_RANGE_BIT  = 3;
  localparam logic [15:0] ADDR_RST  = 16'h0000;
  localparam logic [7:0]  DATA_RST  = 8'h00;
  localparam logic [11:0] ROW_RST   = 12'h000;

  // ---------------------------------------------------------------
  // operations, mode-line codes and states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_PROG   = 2'h0,   // program one main-array byte
    OP_VERIFY = 2'h1,   // read one byte back
    OP_PROG2  = 2'h2,   // two-byte programming pulse
    OP_CHAR   = 2'h3    // program a 12-bit character row as two bytes
  } opv_op_t;

  localparam logic [2:0] MODE_NORMAL = 3'h7;  // lines 2,1,0 = 1,1,1
  localparam logic [2:0] MODE_TWO    = 3'h1;  // lines 2,1,0 = 0,0,1

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b010,
    ST_SECOND = 3'b110
  } opv_state_t;

  // pins driven toward the device
  typedef struct packed {
    logic [7:0] addr_hi;                    // port 0, address bits 15..8
    logic [7:0] addr_lo;                    // port 2, address bits 7..0
    logic [7:0] data;                       // port 3, write data
    logic       data_oe;                    // port 3 output enable
    logic       latch_write_strobe_pin_n;   // write strobe, low pulse
    logic       read_enable_line_n;         // read output enable, low pulse
    logic [2:0] mode_select;                // mode_select_line_2..0
    logic       program_store_pin;          // held low in port mode
    logic       reset_pin;                  // held high in port mode
    logic       programming_voltage_hi;     // selects high programming level
  } opv_pins_t;

endpackage

// >>> design/opv_sync.sv
// two-stage synchroniser for a bus of pin inputs
module opv_sync #(
  parameter int W = 8
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  // ---------------------------------------------------------------
  // per-bit flip-flop pair
  // ---------------------------------------------------------------
  logic [W-1:0] meta_r;   // first stage, read only by the second

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // first stage then second stage
      always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
          meta_r[g] <= 1'b0;
          o_sync[g] <= 1'b0;
        end else begin
          meta_r[g] <= i_async[g];
          o_sync[g] <= meta_r[g];
        end
      end
    end
  endgenerate

endmodule

// >>> design/opv_ctrl.sv
// host controller that programs and verifies the otp array through its pins
//
// Overview of operation
// - port 0 high, port 2 low address
// - port 3 bidirectional data bus
// - write strobe and read enable line
// - high voltage programming, supply for verify
// - reset, store pin, mode lines select operation
// - programming and verify sub-modes
// - char row: 4-bit high, 8-bit low
// - program: reset 1, store 0, modes 111
// - two-byte: mode lines 0,0,1
module opv_ctrl (
  input  wire logic               i_clk_sys,
  input  wire logic               i_sys_rst,
  input  wire logic [4:0]         i_avs_address,
  input  wire logic               i_avs_read,
  input  wire logic               i_avs_write,
  input  wire logic [31:0]        i_avs_writedata,
  input  wire logic [3:0]         i_avs_byteenable,
  output logic      [31:0]        o_avs_readdata,
  output logic                    o_avs_waitrequest,
  input  wire logic [7:0]         i_data,
  output opv_pkg::opv_pins_t      o_pins
);
  import opv_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic             ack_r;       // bus answer cycle
  logic [31:0]      rdbus_r;     // registered read data
  opv_op_t          op_r;        // operation in hand
  logic [15:0]      addr_r;      // array address
  logic [7:0]       wdata_r;     // byte to program
  logic [11:0]      row_r;       // character row pattern
  logic [7:0]       rdata_r;     // byte read back
  logic             done_r;      // sticky completion
  logic             refused_r;   // sticky refused start
  logic             en_r;        // port mode enable
  logic             second_r;    // second byte of a character row
  opv_state_t       st_r;        // sequencer state
  opv_state_t       st_nxt;
  logic [CNT_W-1:0] cnt_r;       // phase counter
  opv_pins_t        pins_r;      // registered pin levels
  opv_pins_t        pins_nxt;
  logic [7:0]       data_sync;   // returning data after two flip-flops

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire        req      = i_avs_read | i_avs_write;
  wire        wr_take  = i_avs_write & ack_r;
  wire [31:0] bmask    = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                          {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire [31:0] wd       = i_avs_writedata & bmask;
  wire        hit_ctrl = wr_take & (i_avs_address == REG_CTRL);
  wire        hit_addr = wr_take & (i_avs_address == REG_ADDR);
  wire        hit_wdat = wr_take & (i_avs_address == REG_WDATA);
  wire        hit_row  = wr_take & (i_avs_address == REG_ROW);
  wire        hit_stat = wr_take & (i_avs_address == REG_STATUS);
  wire        hit_en   = wr_take & (i_avs_address == REG_ENABLE);
  wire        busy     = (st_r != ST_IDLE);
  wire        in_char  = (addr_r >= CHAR_LO) && (addr_r <= CHAR_HI);

  // start request and its acceptance
  wire        go       = hit_ctrl & i_avs_byteenable[0] & i_avs_writedata[CTRL_GO_BIT];
  wire        go_op3   = (opv_op_t'(i_avs_writedata[1:0]) == OP_CHAR);
  wire        accept   = go & en_r & ~busy & (~go_op3 | in_char);
  wire        is_read  = (op_r == OP_VERIFY);

  // status word
  wire [31:0] status_w = {28'h0000000, in_char, refused_r, done_r, busy};

  // read mux, unmapped addresses answer zero
  wire [31:0] rd_mux =
    (i_avs_address == REG_CTRL)   ? {30'h00000000, op_r} :
    (i_avs_address == REG_ADDR)   ? {16'h0000, addr_r} :
    (i_avs_address == REG_WDATA)  ? {24'h000000, wdata_r} :
    (i_avs_address == REG_ROW)    ? {20'h00000, row_r} :
    (i_avs_address == REG_RDATA)  ? {24'h000000, rdata_r} :
    (i_avs_address == REG_STATUS) ? status_w :
    (i_avs_address == REG_ENABLE) ? {31'h00000000, en_r} : 32'h00000000;

  assign o_avs_waitrequest = req & ~ack_r;  // one wait cycle per access
  assign o_avs_readdata    = rdbus_r;
  assign o_pins            = pins_r;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // answer one cycle after the request appears
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ack_r   <= 1'b0;
      rdbus_r <= 32'h00000000;
    end else begin
      ack_r <= req & ~ack_r;
      if (i_avs_read & ~ack_r) begin
        rdbus_r <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // returning data synchroniser
  // ---------------------------------------------------------------
  opv_sync #(
    .W (8)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_data),
    .o_sync    (data_sync)
  );

  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  wire setup_end  = (cnt_r == SETUP_CYC - 1'b1);
  wire [CNT_W-1:0] strobe_cyc = is_read ? READ_CYC : PULSE_CYC;
  wire strobe_end = (cnt_r == strobe_cyc - 1'b1);
  wire hold_end   = (cnt_r == HOLD_CYC - 1'b1);
  wire need_2nd   = (op_r == OP_CHAR) & ~second_r;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE:   if (accept) st_nxt = ST_SETUP;
      ST_SETUP:  if (setup_end) st_nxt = ST_STROBE;
      ST_STROBE: if (strobe_end) st_nxt = ST_HOLD;
      ST_HOLD:   if (hold_end) st_nxt = need_2nd ? ST_SECOND : ST_IDLE;
      ST_SECOND: st_nxt = ST_SETUP;
      default:   st_nxt = ST_IDLE;
    endcase
  end

  // state and phase counter
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_r  <= ST_IDLE;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= (st_nxt != st_r) ? '0 : cnt_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  wire last_done = (st_r == ST_HOLD) & hold_end & ~need_2nd;
  wire [15:0] addr_step = (op_r == OP_CHAR) ? 16'h0002 : 16'h0001;

  // operation, address, data and enable
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      op_r     <= OP_PROG;
      addr_r   <= ADDR_RST;
      wdata_r  <= DATA_RST;
      row_r    <= ROW_RST;
      en_r     <= 1'b0;
      second_r <= 1'b0;
    end else begin
      if (accept) op_r <= opv_op_t'(i_avs_writedata[1:0]);
      if (last_done) begin
        addr_r <= addr_r + addr_step;
      end else if (hit_addr & ~busy) begin
        addr_r <= (addr_r & ~bmask[15:0]) | wd[15:0];
      end
      if (hit_wdat & ~busy & i_avs_byteenable[0]) wdata_r <= wd[7:0];
      if (hit_row & ~busy) row_r <= (row_r & ~bmask[11:0]) | wd[11:0];
      if (hit_en & ~busy & i_avs_byteenable[0]) en_r <= wd[0];
      if (st_r == ST_SECOND) begin
        second_r <= 1'b1;
      end else if (st_r == ST_IDLE) begin
        second_r <= 1'b0;
      end
    end
  end

  // read-back capture and sticky flags, a set beats a clear
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rdata_r   <= DATA_RST;
      done_r    <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (is_read && st_r == ST_STROBE && strobe_end) rdata_r <= data_sync;
      done_r    <= last_done | (done_r & ~(hit_stat & wd[ST_DONE_BIT]));
      refused_r <= (go & ~accept) | (refused_r & ~(hit_stat & wd[ST_REFUSE_BIT]));
    end
  end

  // ---------------------------------------------------------------
  // pin levels
  // ---------------------------------------------------------------
  wire        active  = (st_r == ST_SETUP) | (st_r == ST_STROBE) | (st_r == ST_HOLD);
  wire [15:0] pin_adr = (op_r == OP_CHAR) ? {addr_r[15:1], second_r} : addr_r;
  wire [7:0]  pin_dat = (op_r != OP_CHAR) ? wdata_r :
                        second_r ? {4'h0, row_r[11:8]} : row_r[7:0];
  wire        strobe  = (st_r == ST_STROBE);

  always_comb begin
    pins_nxt = '0;
    pins_nxt.addr_hi = pin_adr[15:8];
    pins_nxt.addr_lo = pin_adr[7:0];
    pins_nxt.data    = pin_dat;
    pins_nxt.data_oe = active & ~is_read;
    pins_nxt.latch_write_strobe_pin_n = ~(strobe & ~is_read);
    pins_nxt.read_enable_line_n       = ~(strobe & is_read);
    pins_nxt.mode_select = (op_r == OP_PROG2) ? MODE_TWO : MODE_NORMAL;
    pins_nxt.program_store_pin      = 1'b0;
    pins_nxt.reset_pin              = en_r;
    pins_nxt.programming_voltage_hi = active & ~is_read;
  end

  // all pins leave through flip-flops
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pins_r <= '0;
      pins_r.latch_write_strobe_pin_n <= 1'b1;
      pins_r.read_enable_line_n       <= 1'b1;
      pins_r.mode_select              <= MODE_NORMAL;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  logic [CNT_W-1:0] we_low_r;  // length of the current write pulse
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      we_low_r <= '0;
    end else begin
      we_low_r <= pins_r.latch_write_strobe_pin_n ? '0 : we_low_r + 1'b1;
    end
  end

  property p_pulse_width;
    $rose(pins_r.latch_write_strobe_pin_n) |-> (we_low_r == PULSE_CYC);
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("write pulse width wrong");

  property p_strobes_apart;
    !(!pins_r.latch_write_strobe_pin_n && !pins_r.read_enable_line_n);
  endproperty
  a_strobes_apart: assert property (p_strobes_apart)
    else $error("write and read strobes low together");

  property p_vpp_prog;
    !pins_r.latch_write_strobe_pin_n |-> pins_r.programming_voltage_hi;
  endproperty
  a_vpp_prog: assert property (p_vpp_prog)
    else $error("write pulse without programming level");

  property p_vpp_verify;
    !pins_r.read_enable_line_n |-> !pins_r.programming_voltage_hi && !pins_r.data_oe;
  endproperty
  a_vpp_verify: assert property (p_vpp_verify)
    else $error("read with high voltage or driven bus");

  property p_oe_width;
    $fell(pins_r.read_enable_line_n) |-> !pins_r.read_enable_line_n[*6] ##1
      pins_r.read_enable_line_n;
  endproperty
  a_oe_width: assert property (p_oe_width)
    else $error("read strobe width wrong");

  property p_two_byte_mode;
    (!pins_r.latch_write_strobe_pin_n && op_r == OP_PROG2) |->
      (pins_r.mode_select == 3'h1);
  endproperty
  a_two_byte_mode: assert property (p_two_byte_mode)
    else $error("two-byte mode lines wrong");

  property p_port_mode;
    !pins_r.latch_write_strobe_pin_n |->
      pins_r.reset_pin && !pins_r.program_store_pin && pins_r.data_oe;
  endproperty
  a_port_mode: assert property (p_port_mode)
    else $error("control pins wrong during write");

  property p_addr_stable;
    (!pins_r.latch_write_strobe_pin_n || !pins_r.read_enable_line_n) |=>
      $stable({pins_r.addr_hi, pins_r.addr_lo, pins_r.data});
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address or data moved during strobe");

  property p_char_range;
    (st_r == ST_STROBE && op_r == OP_CHAR) |->
      ({pins_r.addr_hi, pins_r.addr_lo} inside {[CHAR_LO:CHAR_HI]});
  endproperty
  a_char_range: assert property (p_char_range)
    else $error("character write outside its range");

  c_program: cover property ($rose(done_r) && op_r == OP_PROG);
  c_verify:  cover property ($rose(done_r) && op_r == OP_VERIFY);
  c_char:    cover property (st_r == ST_SECOND);
  c_refused: cover property ($rose(refused_r));

endmodule

// >>> sim/opv_dev_model.sv
// behavioural model of the otp array as seen through its programming pins
module opv_dev_model (
  input  wire opv_pkg::opv_pins_t i_pins,
  input  wire logic               i_clk_sys,
  output logic [7:0]              o_bus,
  output int                      o_bad,
  output int                      o_pulse,
  output logic [2:0]              o_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  import opv_pkg::*;
  // -----------------------------------------------------------
  // storage and bus
  // -----------------------------------------------------------
  logic [7:0] mem [int];     // programmed bytes, erased reads ff
  logic [7:0] last_q;        // previous bus level
  time        t_fall;        // when the current write pulse began
  bit         armed;         // a write pulse is in progress
  wire [15:0] addr = {i_pins.addr_hi, i_pins.addr_lo};
  wire        drv  = i_pins.reset_pin & ~i_pins.read_enable_line_n;
  // stored byte or the erased level
  function automatic logic [7:0] peek(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // host drives, device answers, otherwise no one holds the line
  assign o_bus = i_pins.data_oe ? i_pins.data : drv ? peek(addr) : ~last_q;
  initial begin
    o_bad = 0;
    o_pulse = 0;
    o_mode = 3'h0;
    last_q = 8'h00;
    t_fall = 0;
    armed = 1'b0;
  end
  // bus history and contention
  always @(posedge i_clk_sys) begin
    last_q <= o_bus;
    if (i_pins.data_oe && drv) o_bad++;
  end
  // pin states when a write pulse starts
  always @(negedge i_pins.latch_write_strobe_pin_n) begin
    t_fall = $time;
    armed = 1'b1;
    if (i_pins.reset_pin !== 1'b1 || i_pins.program_store_pin !== 1'b0 ||
        i_pins.programming_voltage_hi !== 1'b1 || i_pins.read_enable_line_n !== 1'b1 ||
        i_pins.data_oe !== 1'b1) o_bad++;
  end
  // pin states when a read pulse starts
  always @(negedge i_pins.read_enable_line_n) begin
    if (i_pins.programming_voltage_hi !== 1'b0 || i_pins.latch_write_strobe_pin_n !== 1'b1 ||
        i_pins.mode_select !== MODE_NORMAL || i_pins.data_oe !== 1'b0) o_bad++;
  end
  // write at the end of the pulse, two-byte mode fills the pair
  always @(posedge i_pins.latch_write_strobe_pin_n) begin
    if (armed) begin
      armed = 1'b0;
      o_pulse = int'(($time - t_fall) / CLK_PERIOD_NS);
      o_mode = i_pins.mode_select;
      if (i_pins.mode_select == MODE_TWO) begin
        mem[{addr[15:1], 1'b0}] = i_pins.data;
        mem[{addr[15:1], 1'b1}] = i_pins.data;
      end else begin
        mem[addr] = i_pins.data;
      end
    end
  end
endmodule

// >>> sim/tb.sv
// self-checking bench for the otp program and verify controller
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import opv_pkg::*;
  logic        clk, rst, rd, wr, waitreq;
  logic [4:0]  adr;
  logic [3:0]  be;
  logic [31:0] wd, rdata, q;
  logic [7:0]  bus;
  opv_pins_t   pins;
  int          dbad, dpulse, fails, compares;
  logic [2:0]  dmode;
  logic [15:0] a;
  logic [7:0]  d [3];
  logic [11:0] row;
  opv_ctrl opv_ctrl_inst (.i_clk_sys(clk), .i_sys_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_data(bus), .o_pins(pins));
  opv_dev_model opv_dev_model_inst (.i_pins(pins), .i_clk_sys(clk), .o_bus(bus),
    .o_bad(dbad), .o_pulse(dpulse), .o_mode(dmode));
  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  function automatic logic [31:0] st_exp(input logic done, input logic refused);
    return (32'(done) << ST_DONE_BIT) | (32'(refused) << ST_REFUSE_BIT);
  endfunction
  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic av(input logic w, input logic [4:0] ad, input logic [31:0] dt);
    int n;
    n = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= ad;
    wd <= dt;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (waitreq !== 1'b0) begin
      fails++;
      end_sim();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // poll busy, check the outcome, clear the sticky flags
  task automatic wait_idle(input logic refused);
    int n;
    n = 0;
    do begin
      av(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (q[ST_BUSY_BIT] !== 1'b0 && n < 3000);
    if (q[ST_BUSY_BIT] !== 1'b0) begin
      fails++;
      end_sim();
    end
    chk(q & 32'h7, st_exp(1'b1, refused));
    av(1'b1, REG_STATUS, 32'h6);
  endtask
  task automatic go(input opv_op_t op);
    av(1'b1, REG_CTRL, (32'h1 << CTRL_GO_BIT) | 32'(op));
  endtask
  // read one byte back through a verify pulse
  task automatic vfy(input logic [15:0] ad, input logic [7:0] exp);
    av(1'b1, REG_ADDR, 32'(ad));
    go(OP_VERIFY);
    wait_idle(1'b0);
    av(1'b0, REG_RDATA, 32'h0);
    chk(q, 32'(exp));
  endtask
  // -----------------------------------------------------------
  // clock and main sequence
  // -----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {rd, wr, adr, wd, be} = {2'h0, 5'h00, 32'h0, 4'hF};
    fails = 0;
    compares = 0;
    void'($urandom(37));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped offset included
    for (int off = 0; off < 32; off += 4) begin
      av(1'b0, 5'(off), 32'h0);
      chk(q, 32'h0);
    end
    chk(32'({pins.latch_write_strobe_pin_n, pins.read_enable_line_n}), 32'h3);
    chk(32'(pins.mode_select), 32'(MODE_NORMAL));
    chk(32'({pins.reset_pin, pins.program_store_pin}), 32'h0);
    // go while disabled is refused
    go(OP_PROG);
    av(1'b0, REG_STATUS, 32'h0);
    chk(q, st_exp(1'b0, 1'b1));
    av(1'b1, REG_STATUS, 32'h6);
    av(1'b1, REG_ENABLE, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'({pins.reset_pin, pins.program_store_pin}), 32'h2);
    // sequential programming with auto-increment, busy refusals on the first
    a = 16'($urandom_range(32'hBFF0));
    av(1'b1, REG_ADDR, 32'(a));
    for (int i = 0; i < 3; i++) begin
      d[i] = 8'($urandom);
      av(1'b1, REG_WDATA, 32'(d[i]));
      go(OP_PROG);
      if (i == 0) begin
        av(1'b1, REG_ADDR, 32'hBEEF);
        go(OP_PROG);
      end
      wait_idle(i == 0);
      chk(32'(dpulse), 32'(PULSE_CYC));
      chk(32'(dmode), 32'(MODE_NORMAL));
    end
    av(1'b0, REG_ADDR, 32'h0);
    chk(q, 32'(a + 16'h3));
    for (int i = 0; i < 3; i++) vfy(a + 16'(i), d[i]);
    vfy(a + 16'h3, 8'hFF);
    // two-byte programming pulse
    a = {16'($urandom_range(32'hBFF0))} & 16'hFFFE;
    d[0] = 8'($urandom);
    av(1'b1, REG_ADDR, 32'(a));
    av(1'b1, REG_WDATA, 32'(d[0]));
    go(OP_PROG2);
    wait_idle(1'b0);
    chk(32'(dmode), 32'(MODE_TWO));
    vfy(a, d[0]);
    vfy(a | 16'h1, d[0]);
    // character rows, random and at the top of the range
    for (int k = 0; k < 2; k++) begin
      a = k == 0 ? CHAR_LO + (16'($urandom_range(32'h1FFE)) & 16'hFFFE) : CHAR_HI - 16'h1;
      row = 12'($urandom);
      av(1'b1, REG_ADDR, 32'(a));
      av(1'b1, REG_ROW, 32'(row));
      av(1'b0, REG_STATUS, 32'h0);
      chk(q, 32'h1 << ST_RANGE_BIT);
      go(OP_CHAR);
      wait_idle(1'b0);
      av(1'b0, REG_ADDR, 32'h0);
      chk(q, 32'(a + 16'h2));
      vfy(a, row[7:0]);
      vfy(a + 16'h1, {4'h0, row[11:8]});
    end
    // character row just above the range is refused
    av(1'b1, REG_ADDR, 32'(CHAR_HI + 16'h1));
    go(OP_CHAR);
    av(1'b0, REG_STATUS, 32'h0);
    chk(q, st_exp(1'b0, 1'b1));
    av(1'b1, REG_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(pins.reset_pin), 32'h0);
    chk(32'(dbad), 32'h0);
    end_sim();
  end
endmodule
